// *** verilog/vepc_pkg.sv ***
// virtual enable power control: shared constants, state and field names
// assumes: an 8-bit register port, byte addresses on 4 bits
package vepc_pkg;

	// ------------------------------------------------------------
	// register port
	// ------------------------------------------------------------
	localparam int unsigned VEPC_ADDR_W = 4;
	localparam int unsigned VEPC_DATA_W = 8;
	localparam logic [3:0] VEPC_OFS_SETTING = 4'h0;
	localparam logic [3:0] VEPC_OFS_STATUS = 4'h4;
	localparam logic [7:0] VEPC_RD_ZERO = 8'h00;
	localparam logic [7:0] VEPC_SETTING_RST = 8'h00;

	// ------------------------------------------------------------
	// setting byte fields
	// ------------------------------------------------------------
	localparam int unsigned VEPC_SET_W = 5;
	localparam int unsigned VEPC_BIT_ENABLE = 0;
	localparam int unsigned VEPC_BIT_RESTART = 1;
	localparam int unsigned VEPC_BIT_RECAL = 2;
	localparam int unsigned VEPC_BIT_RELOAD = 3;
	localparam int unsigned VEPC_BIT_CLRTEST = 4;

	// ------------------------------------------------------------
	// status byte fields
	// ------------------------------------------------------------
	localparam int unsigned VEPC_ST_PHASE_LSB = 0;
	localparam int unsigned VEPC_ST_CALOK = 3;
	localparam int unsigned VEPC_ST_OFS_LSB = 4;
	localparam int unsigned VEPC_OFS_W = 4;
	localparam logic [3:0] VEPC_OFS_RST = 4'h0;

	// ------------------------------------------------------------
	// power sequence states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		VEPC_OFF,
		VEPC_DISABLED,
		VEPC_POR,
		VEPC_NVM,
		VEPC_TEST,
		VEPC_CALCLR,
		VEPC_CAL,
		VEPC_RUN
	} vepc_state_t;

	// power-up options set by pin power-up or kept from the last accepted command
	typedef struct packed {
		logic clrtest;
		logic reload;
		logic recal;
	} vepc_opts_t;

endpackage

// *** verilog/vepc_cmd_if.sv ***
// command and status carrier between register slave and sequencer
// assumes: both ends on the same clock
`timescale 1ns/1ps
interface vepc_cmd_if;
	logic cmd_valid;
	logic [vepc_pkg::VEPC_SET_W-1:0] setting;
	logic [2:0] phase;
	logic cal_ok;
	logic [vepc_pkg::VEPC_OFS_W-1:0] offset;

	modport regs
	(
		output cmd_valid,
		output setting,
		input phase,
		input cal_ok,
		input offset
	);

	modport seq
	(
		input cmd_valid,
		input setting,
		output phase,
		output cal_ok,
		output offset
	);
endinterface

// *** verilog/vepc_regs.sv ***
// register slave of the power control block: setting and status bytes
// assumes: single-cycle strobes, never both at once, read data next cycle
`timescale 1ns/1ps
module vepc_regs
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [vepc_pkg::VEPC_ADDR_W-1:0] reg_addr,
	input wire logic [vepc_pkg::VEPC_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [vepc_pkg::VEPC_DATA_W-1:0] reg_rdata,
	vepc_cmd_if.regs cmd
);

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire logic hit_setting;
	wire logic hit_status;
	wire logic set_wr;
	wire logic [vepc_pkg::VEPC_DATA_W-1:0] status_byte;
	wire logic [vepc_pkg::VEPC_DATA_W-1:0] rd_mux;
	logic [vepc_pkg::VEPC_SET_W-1:0] setting_q;
	logic [vepc_pkg::VEPC_DATA_W-1:0] rdata_q;

	assign hit_setting = (reg_addr == vepc_pkg::VEPC_OFS_SETTING);
	assign hit_status = (reg_addr == vepc_pkg::VEPC_OFS_STATUS);
	// every setting write is taken at once; the slave never stalls
	assign set_wr = reg_wr & hit_setting;
	assign status_byte = {cmd.offset, cmd.cal_ok, cmd.phase};
	// upper three bits of the setting are dropped and read back as zero
	assign rd_mux = hit_setting ? {3'h0, setting_q} :
		hit_status ? status_byte : vepc_pkg::VEPC_RD_ZERO;

	assign cmd.cmd_valid = set_wr;
	assign cmd.setting = reg_wdata[vepc_pkg::VEPC_SET_W-1:0];
	assign reg_rdata = rdata_q;

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			setting_q <= vepc_pkg::VEPC_SETTING_RST[vepc_pkg::VEPC_SET_W-1:0];
			rdata_q <= vepc_pkg::VEPC_RD_ZERO;
		end
		else
		begin
			if (set_wr)
				setting_q <= reg_wdata[vepc_pkg::VEPC_SET_W-1:0];
			rdata_q <= reg_rd ? rd_mux : vepc_pkg::VEPC_RD_ZERO;
		end
	end

endmodule // vepc_regs

// *** verilog/vepc_power_ctrl.sv ***
// virtual enable power control: power-up sequencer behind a setting byte
// assumes: hw_en and all handshakes synchronous to clk; the serial front
// end turns each power command frame into one setting write
//
// Summary of operation
// - hardware enable low switches regulators off, wipes calibration and offset, keeps setting byte
// - hardware enable rising runs full power-up with reload from memory
// - virtual disable keeps regulators and clocks on, state preserved
// - one write frame: address, command code, setting byte; all acked
// - setting bits: 4 clear test, 3 reload, 2 recal, 1 restart, 0 enable
// - enable set while disabled leaves disabled and starts power-up
// - enable clear while operating stops operation, enters disabled
// - restart with enable clear while operating: disable, then power up
// - recal flag clears calibration and recalibrates; else calibration kept
// - calibration skipped only if completed once since state was lost
// - reload flag applies defaults, then memory contents, to working regs
// - reload clear leaves working registers untouched through power-up
// - clear-test flag resets test registers on leaving disabled
// - all-zero setting disables and stays; registers stay writable
// - restart plus recal from disabled or operating: cycle, keep regs, recalibrate
// - clear-test, reload, recal, restart: same as toggling hardware enable
// - reload relatches the sensed address offset; otherwise it is kept
`timescale 1ns/1ps
module vepc_power_ctrl
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic hw_en,
	input wire logic [vepc_pkg::VEPC_ADDR_W-1:0] reg_addr,
	input wire logic [vepc_pkg::VEPC_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [vepc_pkg::VEPC_DATA_W-1:0] reg_rdata,
	output logic regulators_on,
	output logic clocks_run,
	output logic operating,
	output logic regs_write_allow,
	output logic por_apply,
	output logic nvm_load_req,
	input wire logic nvm_load_done,
	output logic test_reset,
	output logic cal_clear,
	output logic cal_req,
	input wire logic cal_done,
	input wire logic [vepc_pkg::VEPC_OFS_W-1:0] addr_offset_sense,
	output logic [vepc_pkg::VEPC_OFS_W-1:0] addr_offset
);

	// ------------------------------------------------------------
	// register slave
	// ------------------------------------------------------------
	vepc_cmd_if cmd_bus ();

	vepc_regs u_regs
	(
		.clk(clk),
		.rst_b(rst_b),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.cmd(cmd_bus.regs)
	);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	vepc_pkg::vepc_state_t state_q;
	vepc_pkg::vepc_state_t state_d;
	vepc_pkg::vepc_opts_t opts_q;
	vepc_pkg::vepc_opts_t opts_d;
	logic pend_q;
	logic pend_d;
	logic cal_ok_q;
	logic cal_ok_d;
	logic [vepc_pkg::VEPC_OFS_W-1:0] ofs_q;

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	wire logic set_enable;
	wire logic set_restart;
	wire vepc_pkg::vepc_opts_t set_opts;
	wire logic in_off;
	wire logic in_disabled;
	wire logic in_oper;
	wire logic cmd_start;
	wire logic cmd_stop;
	wire logic cmd_cycle;

	assign set_enable = cmd_bus.setting[vepc_pkg::VEPC_BIT_ENABLE];
	assign set_restart = cmd_bus.setting[vepc_pkg::VEPC_BIT_RESTART];
	assign set_opts.clrtest = cmd_bus.setting[vepc_pkg::VEPC_BIT_CLRTEST];
	assign set_opts.reload = cmd_bus.setting[vepc_pkg::VEPC_BIT_RELOAD];
	assign set_opts.recal = cmd_bus.setting[vepc_pkg::VEPC_BIT_RECAL];

	assign in_off = (state_q == vepc_pkg::VEPC_OFF);
	assign in_disabled = (state_q == vepc_pkg::VEPC_DISABLED);
	assign in_oper = !in_off && !in_disabled;

	// in disabled, enable or restart starts the power-up
	assign cmd_start = cmd_bus.cmd_valid && in_disabled &&
		(set_enable || set_restart);
	// in operation, enable clear stops; with restart it cycles
	assign cmd_stop = cmd_bus.cmd_valid && in_oper && !set_enable;
	assign cmd_cycle = cmd_stop && set_restart;

	// ------------------------------------------------------------
	// power-up stage selection
	// ------------------------------------------------------------
	wire logic cal_need;
	wire vepc_pkg::vepc_state_t cal_stage;
	wire vepc_pkg::vepc_state_t after_nvm;
	wire vepc_pkg::vepc_state_t first_stage;
	wire vepc_pkg::vepc_opts_t cur_opts;
	wire logic pwr_up_go;

	// a start command shapes its own power-up, not the options parked
	// by the stop command that came before it
	assign cur_opts = cmd_start ? set_opts : opts_q;
	// leave disabled on a start command or on a pending restart
	assign pwr_up_go = pend_q || cmd_start;
	// calibration runs when asked or when no result survives
	assign cal_need = cur_opts.recal || !cal_ok_q;
	assign cal_stage = cal_need ? vepc_pkg::VEPC_CALCLR : vepc_pkg::VEPC_RUN;
	assign after_nvm = cur_opts.clrtest ? vepc_pkg::VEPC_TEST :
		cal_stage;
	// without reload the working registers see no load at all
	assign first_stage = cur_opts.reload ? vepc_pkg::VEPC_POR :
		after_nvm;

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		opts_d = opts_q;
		pend_d = pend_q;
		cal_ok_d = cal_ok_q;
		case (state_q)
			vepc_pkg::VEPC_OFF:
			begin
				cal_ok_d = 1'b0;
				pend_d = 1'b0;
				if (hw_en)
				begin
					// pin power-up: everything rebuilt from memory
					opts_d = '{clrtest: 1'b1, reload: 1'b1, recal: 1'b1};
					state_d = vepc_pkg::VEPC_POR;
				end
			end
			vepc_pkg::VEPC_DISABLED:
			begin
				if (pwr_up_go)
				begin
					pend_d = 1'b0;
					state_d = first_stage;
				end
			end
			vepc_pkg::VEPC_POR:
			begin
				state_d = vepc_pkg::VEPC_NVM;
			end
			vepc_pkg::VEPC_NVM:
			begin
				if (nvm_load_done)
				begin
					state_d = after_nvm;
				end
			end
			vepc_pkg::VEPC_TEST:
			begin
				state_d = cal_stage;
			end
			vepc_pkg::VEPC_CALCLR:
			begin
				cal_ok_d = 1'b0;
				state_d = vepc_pkg::VEPC_CAL;
			end
			vepc_pkg::VEPC_CAL:
			begin
				if (cal_done)
				begin
					cal_ok_d = 1'b1;
					state_d = vepc_pkg::VEPC_RUN;
				end
			end
			vepc_pkg::VEPC_RUN:
			begin
				state_d = vepc_pkg::VEPC_RUN;
			end
			default:
			begin
				state_d = vepc_pkg::VEPC_OFF;
			end
		endcase
		if (cmd_start)
		begin
			opts_d = set_opts;
		end
		if (cmd_stop)
		begin
			state_d = vepc_pkg::VEPC_DISABLED;
			pend_d = cmd_cycle;
			opts_d = set_opts;
		end
		// pin low overrides everything; this block relies on it staying
		// high while the virtual enable is in use
		if (!hw_en)
		begin
			state_d = vepc_pkg::VEPC_OFF;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= vepc_pkg::VEPC_OFF;
			opts_q <= '0;
			pend_q <= 1'b0;
			cal_ok_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			opts_q <= opts_d;
			pend_q <= pend_d;
			cal_ok_q <= cal_ok_d;
		end
	end

	// ------------------------------------------------------------
	// state decode
	// ------------------------------------------------------------
	// one view per sequencer stage; the pulses and request levels
	// below come straight from these
	wire logic in_por;
	wire logic in_nvm;
	wire logic in_test;
	wire logic in_calclr;
	wire logic in_cal;
	wire logic in_run;

	assign in_por = (state_q == vepc_pkg::VEPC_POR);
	assign in_nvm = (state_q == vepc_pkg::VEPC_NVM);
	assign in_test = (state_q == vepc_pkg::VEPC_TEST);
	assign in_calclr = (state_q == vepc_pkg::VEPC_CALCLR);
	assign in_cal = (state_q == vepc_pkg::VEPC_CAL);
	assign in_run = (state_q == vepc_pkg::VEPC_RUN);

	// ------------------------------------------------------------
	// address offset latch
	// ------------------------------------------------------------
	wire logic ofs_load;
	wire logic ofs_clear;

	// latched only when memory is reloaded, by pin or by command
	assign ofs_load = in_nvm && nvm_load_done;
	// losing the pin wipes the latched offset with the rest of the state
	assign ofs_clear = in_off;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ofs_q <= vepc_pkg::VEPC_OFS_RST;
		end
		else if (ofs_clear)
		begin
			ofs_q <= vepc_pkg::VEPC_OFS_RST;
		end
		else if (ofs_load)
		begin
			ofs_q <= addr_offset_sense;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// regulators and clocks stay up through the virtual disable
	assign regulators_on = !in_off;
	assign clocks_run = !in_off;
	assign operating = in_run;
	// register edits are allowed while parked or running
	assign regs_write_allow = in_disabled || in_run;
	assign por_apply = in_por;
	assign nvm_load_req = in_nvm;
	assign test_reset = in_test;
	assign cal_clear = in_calclr;
	assign cal_req = in_cal;
	assign addr_offset = ofs_q;

	assign cmd_bus.phase = state_q;
	assign cmd_bus.cal_ok = cal_ok_q;
	assign cmd_bus.offset = ofs_q;

endmodule // vepc_power_ctrl

// *** test/vepc_power_ctrl_checker.sv ***
// assertions on the power control block ports
// assumes: bound onto vepc_power_ctrl, one clock domain
`timescale 1ns/1ps
module vepc_power_ctrl_checker
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic hw_en,
	input wire logic [vepc_pkg::VEPC_ADDR_W-1:0] reg_addr,
	input wire logic [vepc_pkg::VEPC_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [vepc_pkg::VEPC_DATA_W-1:0] reg_rdata,
	input wire logic regulators_on,
	input wire logic clocks_run,
	input wire logic operating,
	input wire logic regs_write_allow,
	input wire logic por_apply,
	input wire logic nvm_load_req,
	input wire logic nvm_load_done,
	input wire logic cal_clear,
	input wire logic cal_req,
	input wire logic [vepc_pkg::VEPC_OFS_W-1:0] addr_offset
);
	wire logic set_wr = reg_wr && reg_addr == vepc_pkg::VEPC_OFS_SETTING;
	wire logic cmd_ok = set_wr && hw_en;
	wire logic dis = regs_write_allow && !operating;
	wire logic calm = hw_en && !reg_wr;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	chk_pin_off: assert property (!hw_en |=> !regulators_on && !clocks_run)
		else $error("regulators left on");
	chk_pin_up: assert property (hw_en && !regulators_on |=> por_apply)
		else $error("no power-up after pin enable");
	chk_idle_on: assert property (dis |-> regulators_on && clocks_run)
		else $error("power lost while disabled");
	chk_stop_cmd: assert property (operating && cmd_ok && !reg_wdata[0] |=> dis)
		else $error("disable command ignored");
	chk_restart_cal: assert property (operating && cmd_ok
		&& reg_wdata[4:0] == 5'h06 |=> dis ##1 cal_clear)
		else $error("restart with recal wrong");
	chk_wake_load: assert property (dis && cmd_ok && reg_wdata[0]
		&& reg_wdata[3] |=> por_apply)
		else $error("enable with reload did not start");
	chk_por_load: assert property (por_apply && calm |=> nvm_load_req)
		else $error("memory load missing after defaults");
	chk_stay_dis: assert property (dis && calm
		&& !$past(set_wr && reg_wdata[1]) |=> dis)
		else $error("left disabled without command");
	chk_rdata_idle: assert property (!reg_rd
		|=> reg_rdata == vepc_pkg::VEPC_RD_ZERO)
		else $error("read data left standing");
	chk_cal_follow: assert property (cal_clear && calm |=> cal_req)
		else $error("no calibration after clear");
	chk_ofs_keep: assert property (regulators_on && hw_en
		&& !(nvm_load_req && nvm_load_done) |=> $stable(addr_offset))
		else $error("offset changed without reload");
	cov_por: cover property (por_apply);
	cov_calclr: cover property (cal_clear);
	cov_abort: cover property (cal_req && cmd_ok);
endmodule // vepc_power_ctrl_checker

// *** test/vepc_loader_model.sv ***
// memory loader and calibrator stand-in answering sequencer requests
// assumes: requests are levels held until done; slow gives a late answer
`timescale 1ns/1ps
module vepc_loader_model
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic slow,
	input wire logic nvm_load_req,
	input wire logic cal_req,
	output logic nvm_load_done,
	output logic cal_done
);
	logic [3:0] wait_q;
	wire logic [3:0] lat = slow ? 4'h8 : 4'h0;
	wire logic ripe = wait_q == lat;
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			wait_q <= 4'h0;
		else
			wait_q <= (nvm_load_req || cal_req) ? wait_q + 4'h1 : 4'h0;
	// done only while the request stands
	assign nvm_load_done = nvm_load_req && ripe;
	assign cal_done = cal_req && ripe;
endmodule // vepc_loader_model

// *** test/testbench.sv ***
// self-checking bench for the power control block
// assumes: package, interface, design and checker files compiled first
`timescale 1ns/1ps
module testbench;
	logic clk, rst_b, hw_en, reg_wr, reg_rd, slow, clr;
	logic [3:0] reg_addr, sense, addr_offset;
	logic [7:0] reg_wdata, reg_rdata;
	logic [7:0] cnt = 8'h00;
	logic regulators_on, clocks_run, operating, regs_write_allow, por_apply;
	logic nvm_load_req, nvm_load_done, test_reset, cal_clear, cal_req;
	logic cal_done;
	int cyc = 0;
	int err_total = 0;
	int samples_checked = 0;
	vepc_power_ctrl u_vepc_power_ctrl
	(
		.clk(clk), .rst_b(rst_b), .hw_en(hw_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .regulators_on(regulators_on),
		.clocks_run(clocks_run), .operating(operating),
		.regs_write_allow(regs_write_allow), .por_apply(por_apply),
		.nvm_load_req(nvm_load_req), .nvm_load_done(nvm_load_done),
		.test_reset(test_reset), .cal_clear(cal_clear), .cal_req(cal_req),
		.cal_done(cal_done), .addr_offset_sense(sense),
		.addr_offset(addr_offset)
	);
	vepc_loader_model u_vepc_loader_model
	(
		.clk(clk), .rst_b(rst_b), .slow(slow), .nvm_load_req(nvm_load_req),
		.cal_req(cal_req), .nvm_load_done(nvm_load_done), .cal_done(cal_done)
	);
	// pulse counts: power-on defaults, test clear, calibration clear
	always @(posedge clk)
		cnt <= clr ? 8'h00 : {2'b00, cnt[5:4] + {1'b0, por_apply},
			cnt[3:2] + {1'b0, test_reset}, cnt[1:0] + {1'b0, cal_clear}};
	task automatic end_of_test;
		if (err_total == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_total++;
			end_of_test;
		end
	end
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk8(reg_rdata, exp);
	endtask
	// one power command, then pulse counts and status
	task automatic step(input logic [7:0] d, ep, es);
		clr <= 1'b1;
		wr(vepc_pkg::VEPC_OFS_SETTING, d);
		clr <= 1'b0;
		repeat (2) @(posedge clk);
		while (d[1:0] != 2'b00 && operating !== 1'b1)
			@(posedge clk);
		chk8(cnt, ep);
		rd(vepc_pkg::VEPC_OFS_STATUS, es);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial
	begin
		rst_b = 1'b0;
		hw_en = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		slow = 1'b0;
		clr = 1'b0;
		sense = 4'hA;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		while (operating !== 1'b1)
			@(posedge clk);
		chk8(cnt, 8'h15);
		rd(vepc_pkg::VEPC_OFS_STATUS, 8'hAF);
		@(posedge clk);
		sense <= 4'h3;
		step(8'h00, 8'h00, 8'hA9);
		wr(vepc_pkg::VEPC_OFS_SETTING, 8'hE0);
		rd(vepc_pkg::VEPC_OFS_SETTING, 8'h00);
		wr(4'hC, 8'hFF);
		rd(4'h8, 8'h00);
		rd(vepc_pkg::VEPC_OFS_STATUS, 8'hA9);
		step(8'h01, 8'h00, 8'hAF);
		@(posedge clk);
		slow <= 1'b1;
		step(8'h06, 8'h01, 8'hAF);
		step(8'h1A, 8'h14, 8'h3F);
		step(8'h1E, 8'h15, 8'h3F);
		@(posedge clk);
		hw_en <= 1'b0;
		repeat (3) @(posedge clk);
		rd(vepc_pkg::VEPC_OFS_STATUS, 8'h00);
		@(posedge clk);
		hw_en <= 1'b1;
		while (cal_req !== 1'b1)
			@(posedge clk);
		step(8'h00, 8'h00, 8'h31);
		@(posedge clk);
		slow <= 1'b0;
		step(8'h09, 8'h11, 8'h3F);
		end_of_test;
	end
endmodule // testbench
bind vepc_power_ctrl vepc_power_ctrl_checker u_vepc_power_ctrl_checker
(
	.clk(clk), .rst_b(rst_b), .hw_en(hw_en), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .regulators_on(regulators_on),
	.clocks_run(clocks_run), .operating(operating),
	.regs_write_allow(regs_write_allow), .por_apply(por_apply),
	.nvm_load_req(nvm_load_req), .nvm_load_done(nvm_load_done),
	.cal_clear(cal_clear), .cal_req(cal_req), .addr_offset(addr_offset)
);
